// ---- gpio_pkg.sv ----
// Shared constants, types and helpers for the general purpose port block
package gpio_pkg;
	// Port geometry
	localparam int NUM_BYTE_PORTS = 5;
	localparam int BYTE_PORT_W = 8;
	localparam int NIBBLE_PORT_W = 4;
	localparam int NUM_PORTS = NUM_BYTE_PORTS + 1;
	localparam int NUM_PINS = NUM_BYTE_PORTS * BYTE_PORT_W + NIBBLE_PORT_W;
	// Pin held low after an external reset: port 1, bit 0
	localparam int HOLD_PORT = 1;
	localparam int HOLD_BIT = 0;
	localparam int HOLD_PIN_IDX = HOLD_PORT * BYTE_PORT_W + HOLD_BIT;

	// Timing
	localparam longint CLK_HZ = 50_000_000;
	localparam longint PIN_HOLD_MS = 16;
	localparam longint CPU_HOLD_MS = 64;
	localparam int PIN_HOLD_CYCLES = int'(PIN_HOLD_MS * CLK_HZ / 1000);
	localparam int CPU_HOLD_CYCLES = int'(CPU_HOLD_MS * CLK_HZ / 1000);

	// Drive select pair {high bit, low bit}
	localparam logic [1:0] DRV_SEL_LOW_WEAK = 2'h0;
	localparam logic [1:0] DRV_SEL_STRONG = 2'h1;
	localparam logic [1:0] DRV_SEL_HIZ = 2'h2;
	localparam logic [1:0] DRV_SEL_HIGH_WEAK = 2'h3;

	// Interrupt mode pair {high bit, low bit}
	typedef enum logic [1:0] {
		IRQ_OFF = 2'h0,
		IRQ_FALL = 2'h1,
		IRQ_RISE = 2'h2,
		IRQ_CHANGE = 2'h3
	} irq_mode_e;

	// Reset values
	localparam logic [NUM_PINS-1:0] HOLD_MASK = {{(NUM_PINS-1){1'b0}}, 1'b1} << HOLD_PIN_IDX;
	localparam logic [NUM_PINS-1:0] LATCH_RST = '0;
	localparam logic [NUM_PINS-1:0] PAD_OE_N_RST = ~HOLD_MASK;
	localparam logic [NUM_PINS-1:0] PULL_DN_RST = ~HOLD_MASK;
	localparam logic [NUM_PINS-1:0] PULL_UP_RST = '0;

	// Electrical state of one pad
	typedef struct packed {
		logic drive;
		logic level;
		logic pull_up;
		logic pull_dn;
	} pin_drive_s;

	// Port number of a flat pin index
	function automatic logic [2:0] port_of(input int idx);
		port_of = 3'(idx / BYTE_PORT_W);
	endfunction

	// Bit position inside its port of a flat pin index
	function automatic logic [2:0] bit_of(input int idx);
		bit_of = 3'(idx % BYTE_PORT_W);
	endfunction

	// Drive select and output value to pad state
	function automatic pin_drive_s drive_decode(input logic [1:0] sel, input logic val);
		pin_drive_s d;
		d = '0;
		d.level = val;
		if (sel == DRV_SEL_HIZ) begin
			d = '0;
		end else if (!val) begin
			d.drive = (sel != DRV_SEL_LOW_WEAK);
			d.pull_dn = (sel == DRV_SEL_LOW_WEAK);
		end else begin
			d.drive = (sel != DRV_SEL_HIGH_WEAK);
			d.pull_up = (sel == DRV_SEL_HIGH_WEAK);
		end
		drive_decode = d;
	endfunction
endpackage

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_sync
	import gpio_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] stable,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] stable_r;
	logic [WIDTH-1:0] rise_r;
	logic [WIDTH-1:0] fall_r;
	wire [WIDTH-1:0] agree = ~(s2_r ^ s3_r);
	wire [WIDTH-1:0] stable_nxt = (agree & s3_r) | (~agree & stable_r);

	// Synchroniser chain
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Filtered level and one pulse per accepted change
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stable_r <= '0;
			rise_r <= '0;
			fall_r <= '0;
		end else begin
			stable_r <= stable_nxt;
			rise_r <= stable_nxt & ~stable_r;
			fall_r <= ~stable_nxt & stable_r;
		end
	end

	assign stable = stable_r;
	assign rise = rise_r;
	assign fall = fall_r;

	// Edges never fire two cycles running on one bit
	single_edge_a: assert property (@(posedge mclk) disable iff (rst)
		((rise_r | fall_r) & $past(rise_r | fall_r)) == '0)
		else $error("edge pulse repeated on consecutive cycles");
endmodule // pin_sync

// ---- hold_timer.sv ----
// Down-counting hold window, restartable, optionally busy out of reset
`timescale 1ns/1ps
module hold_timer
	import gpio_pkg::*;
#(
	parameter int CYCLES = 16,
	parameter bit START_BUSY = 1'b1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic restart,
	output logic busy
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(1);
	logic [CW-1:0] cnt_r;
	logic busy_r;

	// Window of CYCLES cycles after restart drops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r <= START_BUSY ? LOAD : '0;
			busy_r <= START_BUSY;
		end else if (restart) begin
			cnt_r <= LOAD;
			busy_r <= 1'b1;
		end else if (busy_r) begin
			cnt_r <= cnt_r - LAST;
			busy_r <= (cnt_r != LAST);
		end
	end

	assign busy = busy_r;
endmodule // hold_timer

// ---- gpio_ports.sv ----
// General purpose I/O ports: latches, drive decode, global bus, pin interrupts, reset holds
`timescale 1ns/1ps
module gpio_ports
	import gpio_pkg::*;
#(
	parameter int PIN_HOLD_CYC = PIN_HOLD_CYCLES,
	parameter int CPU_HOLD_CYC = CPU_HOLD_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic external_reset_pin,
	input wire logic [NUM_PORTS-1:0] latch_wr,
	input wire logic [BYTE_PORT_W-1:0] latch_wdata,
	input wire logic [NUM_PORTS-1:0] port_read,
	input wire logic [NUM_PINS-1:0] drive_select_low_bit,
	input wire logic [NUM_PINS-1:0] drive_select_high_bit,
	input wire logic [NUM_PINS-1:0] pin_irq_mode_low_bit,
	input wire logic [NUM_PINS-1:0] pin_irq_mode_high_bit,
	input wire logic [NUM_PINS-1:0] global_bus_connect,
	input wire logic [NUM_PINS-1:0] global_out_line,
	input wire logic [NUM_PINS-1:0] pad_in,
	output logic [NUM_PINS-1:0] pad_out,
	output logic [NUM_PINS-1:0] pad_oe_n,
	output logic [NUM_PINS-1:0] pad_pull_up,
	output logic [NUM_PINS-1:0] pad_pull_dn,
	output logic [NUM_PINS-1:0] global_in_line,
	output logic [NUM_PINS-1:0] pin_state,
	output logic [NUM_PINS-1:0] pin_irq,
	output logic [NUM_PINS-1:0] port_output_latch,
	output logic pin_hold_active,
	output logic cpu_hold_off
);
	// Registered state
	logic [NUM_PINS-1:0] latch_r;
	logic [NUM_PINS-1:0] last_read_r;
	logic [NUM_PINS-1:0] pad_out_r;
	logic [NUM_PINS-1:0] pad_oe_n_r;
	logic [NUM_PINS-1:0] pull_up_r;
	logic [NUM_PINS-1:0] pull_dn_r;
	logic [NUM_PINS-1:0] glob_in_r;
	logic [NUM_PINS-1:0] irq_r;

	// Next values, built per bit
	logic [NUM_PINS-1:0] latch_nxt;
	logic [NUM_PINS-1:0] last_read_nxt;
	logic [NUM_PINS-1:0] pad_out_nxt;
	logic [NUM_PINS-1:0] pad_oe_n_nxt;
	logic [NUM_PINS-1:0] pull_up_nxt;
	logic [NUM_PINS-1:0] pull_dn_nxt;
	logic [NUM_PINS-1:0] glob_in_nxt;
	logic [NUM_PINS-1:0] irq_nxt;

	// Synchronised pins and reset pin, hold timer flags
	logic [NUM_PINS-1:0] pin_level;
	logic [NUM_PINS-1:0] pin_rise;
	logic [NUM_PINS-1:0] pin_fall;
	logic ext_reset_level;
	logic hold_busy;
	logic por_busy;

	// Pad inputs through the agreement synchroniser
	pin_sync #(
		.WIDTH(NUM_PINS)
	) u_pad_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in(pad_in),
		.stable(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// External reset pin through the same synchroniser
	pin_sync #(
		.WIDTH(1)
	) u_xreset_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in(external_reset_pin),
		.stable(ext_reset_level),
		.rise(),
		.fall()
	);

	// Test-mode pin hold: busy while reset pin asserted and for the window after
	hold_timer #(
		.CYCLES(PIN_HOLD_CYC),
		.START_BUSY(1'b1)
	) u_pin_hold (
		.mclk(mclk),
		.rst(rst),
		.restart(ext_reset_level),
		.busy(hold_busy)
	);

	// Power-on hold-off of code execution
	hold_timer #(
		.CYCLES(CPU_HOLD_CYC),
		.START_BUSY(1'b1)
	) u_cpu_hold (
		.mclk(mclk),
		.rst(rst),
		.restart(1'b0),
		.busy(por_busy)
	);

	// Per-pin logic, one independent slice per bit
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		localparam logic [2:0] PORT = port_of(i);
		localparam logic [2:0] BITP = bit_of(i);
		wire [1:0] sel = {drive_select_high_bit[i], drive_select_low_bit[i]};
		wire [1:0] mode = {pin_irq_mode_high_bit[i], pin_irq_mode_low_bit[i]};
		wire is_hiz = (sel == DRV_SEL_HIZ);
		wire glob_rx = global_bus_connect[i] && !is_hiz;
		wire glob_tx = global_bus_connect[i] && is_hiz;
		wire src_val = glob_rx ? global_out_line[i] : latch_r[i];
		wire held = (i == HOLD_PIN_IDX) && hold_busy;
		wire differs = pin_level[i] ^ last_read_r[i];
		pin_drive_s drv;

		// Drive from select pair and output value
		assign drv = drive_decode(sel, src_val);

		// Latch write; the held bit still stores
		assign latch_nxt[i] = latch_wr[PORT] ? latch_wdata[BITP] : latch_r[i];

		// Value seen by the last direct read of this port
		assign last_read_nxt[i] = port_read[PORT] ? pin_level[i] : last_read_r[i];

		// Pad state, overridden low during the hold
		assign pad_out_nxt[i] = held ? 1'b0 : drv.level;
		assign pad_oe_n_nxt[i] = held ? 1'b0 : !drv.drive;
		assign pull_up_nxt[i] = held ? 1'b0 : drv.pull_up;
		assign pull_dn_nxt[i] = held ? 1'b0 : drv.pull_dn;

		// Pin level onto the global input bus
		assign glob_in_nxt[i] = glob_tx && pin_level[i];

		// Interrupt request decode
		assign irq_nxt[i] = (mode == IRQ_FALL && pin_fall[i])
			|| (mode == IRQ_RISE && pin_rise[i])
			|| (mode == IRQ_CHANGE && (pin_rise[i] || pin_fall[i]) && differs);
	end

	// Latches and read snapshot
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			latch_r <= LATCH_RST;
			last_read_r <= '0;
		end else begin
			latch_r <= latch_nxt;
			last_read_r <= last_read_nxt;
		end
	end

	// Pad drive registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pad_out_r <= '0;
			pad_oe_n_r <= PAD_OE_N_RST;
			pull_up_r <= PULL_UP_RST;
			pull_dn_r <= PULL_DN_RST;
		end else begin
			pad_out_r <= pad_out_nxt;
			pad_oe_n_r <= pad_oe_n_nxt;
			pull_up_r <= pull_up_nxt;
			pull_dn_r <= pull_dn_nxt;
		end
	end

	// Global bus and interrupt registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			glob_in_r <= '0;
			irq_r <= '0;
		end else begin
			glob_in_r <= glob_in_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Outputs
	assign pad_out = pad_out_r;
	assign pad_oe_n = pad_oe_n_r;
	assign pad_pull_up = pull_up_r;
	assign pad_pull_dn = pull_dn_r;
	assign global_in_line = glob_in_r;
	assign pin_state = pin_level;
	assign pin_irq = irq_r;
	assign port_output_latch = latch_r;
	assign pin_hold_active = hold_busy;
	assign cpu_hold_off = por_busy;

	// Held pin is driven low
	hold_low_a: assert property (@(posedge mclk) disable iff (rst)
		hold_busy |=> (!pad_out_r[HOLD_PIN_IDX] && !pad_oe_n_r[HOLD_PIN_IDX]))
		else $error("held pin not driven low");

	// Stored latch appears once the hold ends
	hold_release_a: assert property (@(posedge mclk) disable iff (rst)
		(!hold_busy && !global_bus_connect[HOLD_PIN_IDX]
			&& {drive_select_high_bit[HOLD_PIN_IDX], drive_select_low_bit[HOLD_PIN_IDX]} == DRV_SEL_STRONG)
		|=> (pad_out_r[HOLD_PIN_IDX] == $past(latch_r[HOLD_PIN_IDX]) && !pad_oe_n_r[HOLD_PIN_IDX]))
		else $error("held pin latch value not driven after hold");

	// Write to port 1 bit 0 lands even during the hold
	latch_write_a: assert property (@(posedge mclk) disable iff (rst)
		latch_wr[HOLD_PORT] |=> latch_r[HOLD_PIN_IDX] == $past(latch_wdata[HOLD_BIT]))
		else $error("latch write lost");

	// Latch write reaches the pad two cycles later in strong mode
	write_to_pad_a: assert property (@(posedge mclk) disable iff (rst)
		(latch_wr[0] && !global_bus_connect[0] && !drive_select_high_bit[0] && drive_select_low_bit[0])
		##1 (!global_bus_connect[0] && !drive_select_high_bit[0] && drive_select_low_bit[0])
		|=> pad_out_r[0] == $past(latch_wdata[0], 2))
		else $error("latch write not driven on pad");

	// High impedance select releases the pad
	hiz_release_a: assert property (@(posedge mclk) disable iff (rst)
		({drive_select_high_bit[0], drive_select_low_bit[0]} == DRV_SEL_HIZ)
		|=> (pad_oe_n_r[0] && !pull_up_r[0] && !pull_dn_r[0]))
		else $error("high impedance select still drives");

	// Resistive high is a pull-up only
	weak_high_a: assert property (@(posedge mclk) disable iff (rst)
		({drive_select_high_bit[1], drive_select_low_bit[1]} == DRV_SEL_HIGH_WEAK
			&& latch_r[1] && !global_bus_connect[1])
		|=> (pad_oe_n_r[1] && pull_up_r[1] && !pull_dn_r[1]))
		else $error("resistive high decoded wrong");

	// Resistive low is a pull-down only
	weak_low_a: assert property (@(posedge mclk) disable iff (rst)
		({drive_select_high_bit[1], drive_select_low_bit[1]} == DRV_SEL_LOW_WEAK
			&& !latch_r[1] && !global_bus_connect[1])
		|=> (pad_oe_n_r[1] && pull_dn_r[1] && !pull_up_r[1]))
		else $error("resistive low decoded wrong");

	// Connected high impedance pin feeds the global input line
	glob_input_a: assert property (@(posedge mclk) disable iff (rst)
		(global_bus_connect[2] && {drive_select_high_bit[2], drive_select_low_bit[2]} == DRV_SEL_HIZ)
		|=> global_in_line[2] == $past(pin_level[2]))
		else $error("global input line does not follow pin");

	// Connected driving pin follows the global output line
	glob_output_a: assert property (@(posedge mclk) disable iff (rst)
		(global_bus_connect[3] && {drive_select_high_bit[3], drive_select_low_bit[3]} == DRV_SEL_STRONG)
		|=> pad_out_r[3] == $past(global_out_line[3]))
		else $error("pad does not follow global output line");

	// Rising mode answers a rising edge
	irq_rise_a: assert property (@(posedge mclk) disable iff (rst)
		(pin_irq_mode_high_bit[0] && !pin_irq_mode_low_bit[0] && pin_rise[0]) |=> pin_irq[0])
		else $error("rising edge interrupt missing");

	// Disabled mode never requests
	irq_off_a: assert property (@(posedge mclk) disable iff (rst)
		(!pin_irq_mode_high_bit[0] && !pin_irq_mode_low_bit[0]) |=> !pin_irq[0])
		else $error("interrupt while disabled");

	// Power-on hold-off never returns without a reset
	cpu_hold_once_a: assert property (@(posedge mclk) disable iff (rst)
		!cpu_hold_off |=> !cpu_hold_off)
		else $error("cpu hold-off reasserted");

	// Falling mode answers a falling edge
	irq_fall_a: assert property (@(posedge mclk) disable iff (rst)
		(!pin_irq_mode_high_bit[0] && pin_irq_mode_low_bit[0] && pin_fall[0]) |=> pin_irq[0])
		else $error("falling edge interrupt missing");

	// Change mode answers a rise away from the read snapshot
	irq_change_a: assert property (@(posedge mclk) disable iff (rst)
		(pin_irq_mode_high_bit[0] && pin_irq_mode_low_bit[0]
			&& pin_rise[0] && !last_read_r[0]) |=> pin_irq[0])
		else $error("change interrupt missing");

	// No synchronised edge, no request
	irq_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		(!pin_rise[0] && !pin_fall[0]) |=> !pin_irq[0])
		else $error("interrupt without an edge");

	// Unconnected pin leaves its global input line low
	glob_in_off_a: assert property (@(posedge mclk) disable iff (rst)
		!global_bus_connect[2] |=> !global_in_line[2])
		else $error("global input line driven while unconnected");

	// Nibble port write lands in its top bit
	nibble_latch_a: assert property (@(posedge mclk) disable iff (rst)
		latch_wr[NUM_PORTS-1] |=> latch_r[NUM_PINS-1] == $past(latch_wdata[NIBBLE_PORT_W-1]))
		else $error("nibble port write lost");

	// Held pin has both pulls off
	held_pulls_a: assert property (@(posedge mclk) disable iff (rst)
		hold_busy |=> (!pull_up_r[HOLD_PIN_IDX] && !pull_dn_r[HOLD_PIN_IDX]))
		else $error("held pin still pulled");

	// Port 0 latch keeps its value without a write
	latch_keep_a: assert property (@(posedge mclk) disable iff (rst)
		!latch_wr[0] |=> latch_r[BYTE_PORT_W-1:0] == $past(latch_r[BYTE_PORT_W-1:0]))
		else $error("port latch changed without a write");
endmodule // gpio_ports

// ---- pad_board.sv ----
// Board side of the pads: external drivers, resistive pulls and floating pins
`timescale 1ns/1ps
module pad_board
	import gpio_pkg::*;
(
	input wire logic mclk,
	input wire logic [NUM_PINS-1:0] pad_out,
	input wire logic [NUM_PINS-1:0] pad_oe_n,
	input wire logic [NUM_PINS-1:0] pad_pull_up,
	input wire logic [NUM_PINS-1:0] pad_pull_dn,
	input wire logic [NUM_PINS-1:0] board_en,
	input wire logic [NUM_PINS-1:0] board_val,
	output logic [NUM_PINS-1:0] pad_in
);
	logic [NUM_PINS-1:0] last_r = '0;
	// A floating pin flips every cycle, so no settled value is ever assumed
	always_ff @(posedge mclk) begin
		last_r <= pad_in;
	end
	// Strong pad drive wins, then the board, then the pulls
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
			else if (board_en[i]) pad_in[i] = board_val[i];
			else if (pad_pull_up[i]) pad_in[i] = 1'b1;
			else if (pad_pull_dn[i]) pad_in[i] = 1'b0;
			else pad_in[i] = ~last_r[i];
		end
	end
endmodule // pad_board

// ---- test_gpio_ports.sv ----
// Self-checking bench for the general purpose port block
`timescale 1ns/1ps
module test_gpio_ports
	import gpio_pkg::*;
;
	localparam int PH = 20;
	localparam int CH = 60;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ext_rst = 1'b0;
	logic [NUM_PORTS-1:0] latch_wr = '0;
	logic [NUM_PORTS-1:0] port_read = '0;
	logic [BYTE_PORT_W-1:0] wdata = '0;
	logic [NUM_PINS-1:0] dsl = '0, dsh = '0, iml = '0, imh = '0, gbc = '0, gol = '0, ben = '0, bval = '0;
	logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_dn, global_in_line, pin_state, pin_irq;
	logic [NUM_PINS-1:0] port_output_latch, m_latch, hit_r, hit_f;
	logic pin_hold_active, cpu_hold_off;
	bit [31:0] seed = 32'hc;
	int n_errors = 0;
	int checks_done = 0;
	int n;
	int tot;

	gpio_ports #(.PIN_HOLD_CYC(PH), .CPU_HOLD_CYC(CH)) u_dut (.mclk(mclk), .rst(rst),
		.external_reset_pin(ext_rst), .latch_wr(latch_wr), .latch_wdata(wdata), .port_read(port_read),
		.drive_select_low_bit(dsl), .drive_select_high_bit(dsh), .pin_irq_mode_low_bit(iml),
		.pin_irq_mode_high_bit(imh), .global_bus_connect(gbc), .global_out_line(gol), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn),
		.global_in_line(global_in_line), .pin_state(pin_state), .pin_irq(pin_irq),
		.port_output_latch(port_output_latch), .pin_hold_active(pin_hold_active), .cpu_hold_off(cpu_hold_off));

	pad_board u_board (.mclk(mclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up(pad_pull_up),
		.pad_pull_dn(pad_pull_dn), .board_en(ben), .board_val(bval), .pad_in(pad_in));

	// Clock at 50 MHz
	initial begin
		forever #10 mclk = ~mclk;
	end

	// Xorshift source of stimulus
	function automatic logic [NUM_PINS-1:0] rnd();
		logic [63:0] w;
		for (int k = 0; k < 2; k++) begin
			seed ^= seed << 13;
			seed ^= seed >> 17;
			seed ^= seed << 5;
			w = {w[31:0], seed};
		end
		rnd = w[NUM_PINS-1:0];
	endfunction

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [NUM_PINS-1:0] seen, input logic [NUM_PINS-1:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic ticks(input int k);
		repeat (k) @(negedge mclk);
	endtask

	// Bounded wait for a hold flag to reach a level
	task automatic wait_flag(input bit cpu, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while ((cpu ? cpu_hold_off : pin_hold_active) !== lvl) begin
			if (cnt >= lim) begin
				n_errors++;
				$display("BAD %0t hold flag wait ran out", $time);
				end_sim();
			end
			@(negedge mclk);
			cnt++;
		end
	endtask

	// Back to back latch writes, one port per cycle
	task automatic write_all();
		logic [NUM_PINS-1:0] r;
		r = rnd();
		for (int p = 0; p < NUM_PORTS; p++) begin
			@(negedge mclk);
			latch_wr = NUM_PORTS'(1) << p;
			wdata = BYTE_PORT_W'(r >> (p * BYTE_PORT_W));
			for (int b = 0; b < (p < NUM_BYTE_PORTS ? BYTE_PORT_W : NIBBLE_PORT_W); b++) m_latch[p*8+b] = wdata[b];
		end
		@(negedge mclk);
		latch_wr = '0;
	endtask

	// Expected pad state from the drive table
	task automatic check_pads(input bit held);
		logic [NUM_PINS-1:0] eo, en, eu, ed;
		logic [1:0] s;
		logic v;
		for (int i = 0; i < NUM_PINS; i++) begin
			s = {dsh[i], dsl[i]};
			v = gbc[i] ? gol[i] : m_latch[i];
			en[i] = (s == DRV_SEL_HIZ) || (s == (v ? DRV_SEL_HIGH_WEAK : DRV_SEL_LOW_WEAK));
			eo[i] = v;
			eu[i] = v && s == DRV_SEL_HIGH_WEAK;
			ed[i] = !v && s == DRV_SEL_LOW_WEAK;
			if (held && i == HOLD_PIN_IDX) {en[i], eo[i], eu[i], ed[i]} = 4'h0;
		end
		check(port_output_latch, m_latch, "latch");
		check(pad_oe_n, en, "oe_n");
		check(pad_out & ~en, eo & ~en, "out");
		check(pad_pull_up, eu, "pull up");
		check(pad_pull_dn, ed, "pull down");
	endtask

	// Main sequence
	initial begin
		m_latch = '0;
		dsl = '1;
		ticks(4);
		check(NUM_PINS'(pin_hold_active), NUM_PINS'(1), "hold at reset");
		check(pad_oe_n, PAD_OE_N_RST, "oe_n at reset");
		rst = 1'b0;
		write_all();
		ticks(2);
		check_pads(1'b1);
		wait_flag(1'b0, 1'b0, PH + 4, n);
		// Nine falling edges pass between release and the start of this wait
		check(NUM_PINS'(n + 9 >= PH && n + 9 <= PH + 2), NUM_PINS'(1), "pin hold length");
		ticks(3);
		check_pads(1'b0);
		wait_flag(1'b1, 1'b0, CH, n);
		// Twenty-three falling edges pass between release and the start of this wait
		check(NUM_PINS'(n + 23 >= CH - 1 && n + 23 <= CH + 2), NUM_PINS'(1), "cpu hold length");
		$display("test reset holds done");
		// Random drive tables, latches and global output bus
		for (int it = 0; it < 10; it++) begin
			dsl = rnd();
			dsh = rnd();
			gbc = (it > 5) ? rnd() : '0;
			gol = rnd();
			write_all();
			ticks(3);
			check_pads(1'b0);
		end
		$display("test drive done");
		// Inputs on high impedance pins, global input bus
		dsl = '0;
		dsh = '1;
		ben = '1;
		bval = rnd();
		gbc = '0;
		ticks(8);
		check(pin_state, bval, "pin read");
		check(global_in_line, '0, "global in off");
		gbc = rnd();
		ticks(4);
		check(global_in_line, bval & gbc, "global in");
		$display("test input done");
		// Interrupt modes: read at low, raise, fall
		gbc = '0;
		for (int m = 0; m < 4; m++) begin
			bval = '0;
			ticks(8);
			port_read = '1;
			ticks(1);
			port_read = '0;
			{iml, imh} = {{NUM_PINS{m[0]}}, {NUM_PINS{m[1]}}};
			ticks(2);
			tot = 0;
			hit_r = '0;
			hit_f = '0;
			bval = '1;
			for (int k = 0; k < 10; k++) begin
				ticks(1);
				hit_r |= pin_irq;
				tot += $countones(pin_irq);
			end
			bval = '0;
			for (int k = 0; k < 10; k++) begin
				ticks(1);
				hit_f |= pin_irq;
				tot += $countones(pin_irq);
			end
			check(hit_r, (m == 2 || m == 3) ? '1 : '0, "irq rise");
			check(hit_f, (m == 1) ? '1 : '0, "irq fall");
			check(NUM_PINS'(tot), NUM_PINS'(m == 0 ? 0 : NUM_PINS), "irq count");
		end
		$display("test interrupts done");
		// External reset re-arms the pin hold only
		dsl = '1;
		dsh = '0;
		ben = '0;
		ext_rst = 1'b1;
		ticks(3);
		ext_rst = 1'b0;
		wait_flag(1'b0, 1'b1, 10, n);
		write_all();
		dsh[HOLD_PIN_IDX] = 1'b1;
		ticks(3);
		check_pads(1'b1);
		check(NUM_PINS'(cpu_hold_off), NUM_PINS'(0), "cpu hold stays off");
		wait_flag(1'b0, 1'b0, PH + 12, n);
		ticks(3);
		check_pads(1'b0);
		$display("test external reset done");
		end_sim();
	end
endmodule // test_gpio_ports
